// ===== bench/ssnp_asserts.sv
// port-level checker for the serial-to-network packer
// assumes it is bound to ssnp_packer and mirrors only CTRL and DELIM writes
`timescale 1ns/1ps
module ssnp_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic ser_rx_valid,
  input wire logic ser_rx_ready,
  input wire logic frm_valid,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_tx_ready,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_tx_valid,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_open,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  input wire logic [ssnp_pkg::HOSTS-1:0] drv_cmd_valid,
  input wire logic ctrl_word_valid
);
  logic en_q, skip_q, drv_q, dz_q;
  logic [2:0] hosts_q;
  wire ctrl_wr = reg_wr && reg_addr == ssnp_pkg::ADDR_CTRL;
  wire delim_wr = reg_wr && reg_addr == ssnp_pkg::ADDR_DELIM;
  wire [2:0] hosts_w = reg_wdata[6:4];
  wire [2:0] next_hosts = hosts_w == 3'h0 ? 3'h1 : (hosts_w > 3'h4 ? 3'h4 : hosts_w);
  wire [ssnp_pkg::HOSTS-1:0] open_rdy = host_open & host_tx_ready;
  wire cmd_ok = en_q && |(drv_cmd_valid & host_open) && (hosts_q == 3'h1 || drv_q);
  // shadow of the settings the port rules depend on
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {en_q, skip_q, drv_q, dz_q} <= 4'hB;
      hosts_q <= 3'h1;
    end else begin
      if (ctrl_wr) {drv_q, skip_q, en_q} <= reg_wdata[2:0];
      if (ctrl_wr) hosts_q <= next_hosts;
      if (delim_wr) dz_q <= reg_wdata[7:0] == 8'h00;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_disable_rx: assert property (!en_q |-> !ser_rx_ready)
    else $error("serial input ready on a disabled port");
  a_disable_close: assert property (!en_q |=> host_open == '0)
    else $error("host session open on a disabled port");
  a_host_limit: assert property ($countones(host_open) <= hosts_q)
    else $error("more sessions open than the host limit");
  a_no_delim_emit: assert property (dz_q && ser_rx_valid && ser_rx_ready |=> frm_valid)
    else $error("byte not released at once without a delimiter");
  a_tx_to_open: assert property (host_tx_valid != '0 |-> frm_valid && (host_tx_valid & ~open_rdy) == '0)
    else $error("frame byte sent to a closed or busy host");
  a_wait_all: assert property (!skip_q && host_tx_valid != '0 |-> (host_open & ~host_tx_ready) == '0)
    else $error("byte sent while an open host stalls");
  a_skip_stalled: assert property (skip_q && hosts_q > 3'h1 && frm_valid && open_rdy != '0
    |-> host_tx_valid == open_rdy)
    else $error("ready hosts held back by a stalled host");
  a_cmd_accept: assert property (ctrl_word_valid == $past(cmd_ok))
    else $error("driver command acceptance wrong");
  a_ser_hold: assert property (ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
    else $error("serial output byte changed before acceptance");
endmodule : ssnp_asserts

// ===== bench/ssnp_far_model.sv
// far side: remote hosts taking frame bytes, serial device taking network bytes
// assumes slow and stall_mask change on core_clk edges
`timescale 1ns/1ps
module ssnp_far_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [ssnp_pkg::HOSTS-1:0] stall_mask,
  output logic [ssnp_pkg::HOSTS-1:0] host_tx_ready,
  output logic ser_tx_ready
);
  integer seed = 23;
  logic [ssnp_pkg::HOSTS-1:0] jit = '0;
  logic sjit = 1'b0;
  always @(posedge core_clk) begin
    jit <= slow ? 4'($random(seed)) : 4'h0;
    sjit <= slow ? 1'($random(seed)) : 1'b0;
  end
  // a stalled host never takes a byte until released
  assign host_tx_ready = ~(stall_mask | jit);
  assign ser_tx_ready = !sjit;
endmodule : ssnp_far_model

// ===== bench/ssnp_packer_tb.sv
// self-checking bench for ssnp_packer: registers, packing triggers, host policy
// assumes ssnp_pkg, ssnp_far_model and ssnp_asserts are compiled before it
`timescale 1ns/1ps
module ssnp_packer_tb;
  logic core_clk, rstn, reg_wr, reg_rd, ser_rx_valid, ser_tx_valid, ser_tx_ready, slow;
  logic frm_valid, ser_rx_ready, ctrl_word_valid, r;
  logic [7:0] reg_addr, ser_rx_data, ser_tx_data, b;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] ctrl_word, line_cfg;
  logic [3:0] host_tx_ready, host_tx_valid, host_conn_req, host_disc, host_open;
  logic [3:0] host_rx_valid, host_rx_ready, drv_cmd_valid, stall_mask;
  logic [3:0][7:0] host_rx_data;
  logic [3:0][15:0] drv_cmd;
  ssnp_pkg::ssnp_frm_t frm;
  integer seed = 23, miscompares = 0, checks_done = 0;
  logic [8:0] got[$], exp[$];
  logic [7:0] sgot[$], sexp[$];
  ssnp_packer #(.MS_CYCLES(10)) ssnp_packer_i (.core_clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ser_rx_valid, .ser_rx_data, .ser_rx_ready, .frm_valid,
    .frm, .host_tx_ready, .host_tx_valid, .host_conn_req, .host_disc, .host_open,
    .host_rx_valid, .host_rx_data, .host_rx_ready, .ser_tx_valid, .ser_tx_data,
    .ser_tx_ready, .drv_cmd_valid, .drv_cmd, .ctrl_word, .ctrl_word_valid, .line_cfg);
  ssnp_far_model ssnp_far_model_i (.core_clk, .slow, .stall_mask, .host_tx_ready,
    .ser_tx_ready);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rstn && host_tx_valid[0]) got.push_back(frm);
    if (rstn && ser_tx_valid && ser_tx_ready) sgot.push_back(ser_tx_data);
  end
  function automatic logic [7:0] rb();
    return (8'($random(seed)) & 8'h7F) | 8'h20;
  endfunction : rb
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk) chk(reg_rdata, e, "register read");
    @(posedge core_clk);
  endtask : rd
  task automatic pk(input logic [7:0] d, input logic keep);
    ser_rx_valid <= 1'b1;
    ser_rx_data <= d;
    @(posedge core_clk);
    if (keep) exp.push_back({d, 1'b0});
  endtask : pk
  task automatic seal();
    exp[exp.size()-1][0] = 1'b1;
  endtask : seal
  task automatic cmpq(input int w, input string n);
    ser_rx_valid <= 1'b0;
    repeat (w) @(posedge core_clk);
    chk(got.size(), exp.size(), n);
    foreach (exp[i]) chk(got[i], exp[i], n);
    got.delete();
    exp.delete();
    $display("test %s done", n);
  endtask : cmpq
  task automatic conn(input logic [3:0] m, input logic [3:0] e);
    host_conn_req <= m;
    repeat (2) @(posedge core_clk);
    host_conn_req <= 4'h0;
    @(negedge core_clk) chk(host_open, e, "sessions open");
    @(posedge core_clk);
  endtask : conn
  task automatic cmd(input logic [3:0] m, input logic [15:0] e);
    drv_cmd_valid <= m;
    drv_cmd <= {16'($random(seed)), 16'($random(seed)), 16'h5555, 16'hAAAA};
    @(posedge core_clk);
    drv_cmd_valid <= 4'h0;
    @(posedge core_clk);
    @(negedge core_clk) chk(ctrl_word, e, "control word");
    @(posedge core_clk);
  endtask : cmd
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {rstn, reg_wr, reg_rd, ser_rx_valid, slow, reg_addr, reg_wdata, ser_rx_data} = '0;
    {host_conn_req, host_disc, host_rx_valid, drv_cmd_valid, stall_mask} = '0;
    host_rx_data = '0;
    drv_cmd = '0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(ssnp_pkg::ADDR_CTRL, 32'h0000_0715);
    rd(ssnp_pkg::ADDR_PACK, 32'h0000_0000);
    rd(ssnp_pkg::ADDR_FORCE, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    wr(ssnp_pkg::ADDR_CTRL, 32'h0000_0705);
    rd(ssnp_pkg::ADDR_CTRL, 32'h0000_0715);
    conn(4'h3, 4'h1);
    rd(ssnp_pkg::ADDR_STAT, 32'h0000_1000);
    for (int i = 0; i < 4; i++) pk(8'($random(seed)), 1'b1);
    foreach (exp[i]) exp[i][0] = 1'b1;
    cmpq(20, "no delimiter");
    // every delimiter step; random fill avoids the delimiter codes
    for (int p = 0; p < 4; p++) begin
      wr(ssnp_pkg::ADDR_DELIM, 32'h0000_000D);
      wr(ssnp_pkg::ADDR_PACK, p << 16);
      repeat (3) pk(rb(), 1'b1);
      pk(8'h0D, p != 3);
      for (int k = 0; k < p && p < 3; k++) pk(rb(), 1'b1);
      seal();
      cmpq(20, "delimiter step");
    end
    wr(ssnp_pkg::ADDR_PACK, 32'h0000_0000);
    wr(ssnp_pkg::ADDR_DELIM, 32'h0000_0A0D);
    sexp.delete();
    pk(8'h41, 1'b1);
    pk(8'h0D, 1'b1);
    pk(8'h42, 1'b1);
    pk(8'h0D, 1'b1);
    pk(8'h0A, 1'b1);
    seal();
    cmpq(20, "two-byte delimiter");
    wr(ssnp_pkg::ADDR_DELIM, 32'h0000_00FF);
    wr(ssnp_pkg::ADDR_PACK, 32'h0000_0005);
    wr(ssnp_pkg::ADDR_FORCE, 32'h0000_0003);
    for (int i = 0; i < 12; i++) begin
      pk(rb(), 1'b1);
      if (i == 4 || i == 9) seal();
    end
    seal();
    ser_rx_valid <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk(got.size(), 10, "early timeout");
    cmpq(40, "length and timeout");
    wr(ssnp_pkg::ADDR_FORCE, 32'h0000_0000);
    wr(ssnp_pkg::ADDR_PACK, 32'h0000_0000);
    for (int i = 0; i < ssnp_pkg::BUF_BYTES; i++) pk(rb(), 1'b1);
    seal();
    cmpq(1040, "full buffer");
    wr(ssnp_pkg::ADDR_CTRL, 32'h0000_0725);
    conn(4'h2, 4'h3);
    wr(ssnp_pkg::ADDR_DELIM, 32'h0000_0000);
    stall_mask <= 4'h2;
    pk(rb(), 1'b1);
    seal();
    ser_rx_valid <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(got.size(), 0, "stalled host held");
    stall_mask <= 4'h0;
    cmpq(10, "wait for all hosts");
    wr(ssnp_pkg::ADDR_CTRL, 32'h0000_0727);
    stall_mask <= 4'h2;
    pk(rb(), 1'b1);
    seal();
    cmpq(10, "skip stalled host");
    stall_mask <= 4'h0;
    wr(ssnp_pkg::ADDR_LINE, 32'h0000_1234);
    repeat (2) @(posedge core_clk);
    chk(line_cfg, 16'h1234, "line settings");
    wr(ssnp_pkg::ADDR_CTRL, 32'h0000_0723);
    cmd(4'h1, 16'h0000);
    wr(ssnp_pkg::ADDR_CTRL, 32'h0000_0727);
    cmd(4'h3, 16'hAAAA);
    cmd(4'h2, 16'h5555);
    rd(ssnp_pkg::ADDR_CMD, 32'h0000_5555);
    chk(line_cfg, 16'h1234, "line after command");
    slow <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      b = rb();
      sexp.push_back(b);
      host_rx_valid <= 4'h1;
      host_rx_data[0] <= b;
      r = 1'b0;
      for (int k = 0; k < 50 && !r; k++) begin
        @(negedge core_clk) r = host_rx_ready[0];
        @(posedge core_clk);
      end
    end
    host_rx_valid <= 4'h0;
    repeat (30) @(posedge core_clk);
    chk(sgot.size(), sexp.size(), "serial count");
    foreach (sexp[i]) chk(sgot[i], sexp[i], "serial order");
    $display("test network to serial done");
    slow <= 1'b0;
    wr(ssnp_pkg::ADDR_CTRL, 32'h0000_0726);
    @(negedge core_clk) chk(ser_rx_ready, 1'b0, "disabled input");
    @(posedge core_clk);
    conn(4'h1, 4'h0);
    $display("test disable done");
    tally_and_finish();
  end
endmodule : ssnp_packer_tb
bind ssnp_packer ssnp_asserts ssnp_asserts_i (.core_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .ser_rx_valid, .ser_rx_ready, .frm_valid, .host_tx_ready, .host_tx_valid,
  .host_open, .ser_tx_valid, .ser_tx_data, .ser_tx_ready, .drv_cmd_valid, .ctrl_word_valid);

// ===== pkg/ssnp_pkg.sv
// constants, field layout and carrier types of the serial-to-network packer
// assumes a 25 MHz core clock and one serial port per packer instance
package ssnp_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MIN_MS = 60_000;
  localparam int BUF_BYTES = 1024;
  localparam int HOSTS = 4;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PACK = 8'h04;
  localparam logic [7:0] ADDR_DELIM = 8'h08;
  localparam logic [7:0] ADDR_FORCE = 8'h0C;
  localparam logic [7:0] ADDR_LINE = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SKIP_BIT = 1;
  localparam int CTRL_DRV_BIT = 2;
  localparam int CTRL_HOSTS_LSB = 4;
  localparam int CTRL_ALIVE_LSB = 8;
  localparam int PACK_LEN_LSB = 0;
  localparam int PACK_PROC_LSB = 16;
  localparam int DELIM1_LSB = 0;
  localparam int DELIM2_LSB = 8;

  localparam logic [2:0] HOSTS_MIN = 3'h1;
  localparam logic [2:0] HOSTS_MAX = 3'h4;

  typedef enum logic [1:0] {
    SSNP_PROC_NONE = 2'h0,
    SSNP_PROC_PLUS1 = 2'h1,
    SSNP_PROC_PLUS2 = 2'h2,
    SSNP_PROC_STRIP = 2'h3
  } ssnp_proc_t;

  typedef enum logic [1:0] {
    SSNP_PS_IDLE = 2'b00,
    SSNP_PS_WAIT2 = 2'b01,
    SSNP_PS_WAIT1 = 2'b11
  } ssnp_post_t;

  typedef struct packed {
    logic en;
    logic skip;
    logic drv;
    logic [2:0] hosts;
    logic [6:0] alive;
    logic [10:0] len;
    ssnp_proc_t proc;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [15:0] force_ms;
    logic [15:0] line;
  } ssnp_cfg_t;

  localparam ssnp_cfg_t CFG_RST = '{en: 1'b1, skip: 1'b0, drv: 1'b1, hosts: 3'h1,
    alive: 7'h07, len: 11'h000, proc: SSNP_PROC_NONE, d1: 8'h00, d2: 8'h00,
    force_ms: 16'h0000, line: 16'h0000};

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } ssnp_frm_t;
endpackage : ssnp_pkg

// ===== src/ssnp_host_slot.sv
// one network host session: open flag and idle-connection timer
// assumes min_tick is a one-cycle pulse once per minute on core_clk
`timescale 1ns/1ps
module ssnp_host_slot (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic open_req,
  input wire logic close_req,
  input wire logic activity,
  input wire logic min_tick,
  input wire logic [6:0] alive_min,
  output logic open
);
  logic [6:0] idle_min;

  // closes only after at least alive_min whole minutes without activity
  wire expire = open && min_tick && !activity && alive_min != 7'h00 &&
                idle_min >= alive_min;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      open <= 1'b0;
    end else if (close_req || expire) begin
      open <= 1'b0;
    end else if (open_req) begin
      open <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || activity || !open || open_req) begin
      idle_min <= 7'h00;
    end else if (min_tick && idle_min != 7'h7F) begin
      idle_min <= idle_min + 7'h01;
    end
  end
endmodule : ssnp_host_slot

// ===== src/ssnp_packer.sv
// serial-to-network packer for one port: frame buffer, triggers, host policy
// assumes all byte streams and host signals come from logic on core_clk
`timescale 1ns/1ps
module ssnp_packer #(
  parameter int MS_CYCLES = ssnp_pkg::MS_CYCLES,
  parameter int BUF_BYTES = ssnp_pkg::BUF_BYTES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  output logic ser_rx_ready,
  output logic frm_valid,
  output ssnp_pkg::ssnp_frm_t frm,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_tx_ready,
  output logic [ssnp_pkg::HOSTS-1:0] host_tx_valid,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_conn_req,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_disc,
  output logic [ssnp_pkg::HOSTS-1:0] host_open,
  input wire logic [ssnp_pkg::HOSTS-1:0] host_rx_valid,
  input wire logic [ssnp_pkg::HOSTS-1:0][7:0] host_rx_data,
  output logic [ssnp_pkg::HOSTS-1:0] host_rx_ready,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  input wire logic [ssnp_pkg::HOSTS-1:0] drv_cmd_valid,
  input wire logic [ssnp_pkg::HOSTS-1:0][15:0] drv_cmd,
  output logic [15:0] ctrl_word,
  output logic ctrl_word_valid,
  output logic [15:0] line_cfg
);
  localparam int H = ssnp_pkg::HOSTS;
  localparam int AW = $clog2(BUF_BYTES);
  localparam int DW = $clog2(MS_CYCLES);
  localparam logic [AW:0] CAP = (AW+1)'(BUF_BYTES);
  localparam logic [AW:0] ONE = (AW+1)'(1);

  // lowest-index set bit, one-hot
  function automatic logic [H-1:0] ssnp_first(input logic [H-1:0] v);
    logic [H-1:0] r;
    logic found;
    r = '0;
    found = 1'b0;
    for (int i = 0; i < H; i++) begin
      if (v[i] && !found) begin
        r[i] = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction : ssnp_first

  function automatic logic [2:0] ssnp_count(input logic [H-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < H; i++) begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction : ssnp_count

  ssnp_pkg::ssnp_cfg_t cfg;

  // register write decode
  wire wr_ctrl = reg_wr && reg_addr == ssnp_pkg::ADDR_CTRL;
  wire wr_pack = reg_wr && reg_addr == ssnp_pkg::ADDR_PACK;
  wire wr_delim = reg_wr && reg_addr == ssnp_pkg::ADDR_DELIM;
  wire wr_force = reg_wr && reg_addr == ssnp_pkg::ADDR_FORCE;
  wire wr_line = reg_wr && reg_addr == ssnp_pkg::ADDR_LINE;
  wire [2:0] w_hosts = reg_wdata[ssnp_pkg::CTRL_HOSTS_LSB +: 3];
  wire [2:0] clip_hosts = (w_hosts < ssnp_pkg::HOSTS_MIN) ? ssnp_pkg::HOSTS_MIN :
                          (w_hosts > ssnp_pkg::HOSTS_MAX) ? ssnp_pkg::HOSTS_MAX : w_hosts;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg <= ssnp_pkg::CFG_RST;
    end else begin
      if (wr_ctrl) begin
        cfg.en <= reg_wdata[ssnp_pkg::CTRL_EN_BIT];
        cfg.skip <= reg_wdata[ssnp_pkg::CTRL_SKIP_BIT];
        cfg.drv <= reg_wdata[ssnp_pkg::CTRL_DRV_BIT];
        cfg.hosts <= clip_hosts;
        cfg.alive <= reg_wdata[ssnp_pkg::CTRL_ALIVE_LSB +: 7];
      end
      if (wr_pack) begin
        cfg.len <= reg_wdata[ssnp_pkg::PACK_LEN_LSB +: 11];
        cfg.proc <= ssnp_pkg::ssnp_proc_t'(reg_wdata[ssnp_pkg::PACK_PROC_LSB +: 2]);
      end
      if (wr_delim) begin
        cfg.d1 <= reg_wdata[ssnp_pkg::DELIM1_LSB +: 8];
        cfg.d2 <= reg_wdata[ssnp_pkg::DELIM2_LSB +: 8];
      end
      if (wr_force) begin
        cfg.force_ms <= reg_wdata[15:0];
      end
      if (wr_line) begin
        cfg.line <= reg_wdata[15:0];
      end
    end
  end

  // millisecond and minute ticks
  logic [DW-1:0] ms_div;
  logic [15:0] min_div;
  wire ms_tick = ms_div == DW'(MS_CYCLES - 1);
  wire min_tick = ms_tick && min_div == 16'(ssnp_pkg::MIN_MS - 1);

  always_ff @(posedge core_clk) begin
    if (!rstn || ms_tick) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_div + DW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || min_tick) begin
      min_div <= 16'h0000;
    end else if (ms_tick) begin
      min_div <= min_div + 16'h0001;
    end
  end

  // frame buffer
  logic [7:0] buf_mem [BUF_BYTES];
  logic [BUF_BYTES-1:0] last_bits;
  logic [AW:0] wr_ptr;
  logic [AW:0] cmt_ptr;
  logic [AW:0] rd_ptr;
  logic saw_d1;
  logic [16:0] idle_ms;
  ssnp_pkg::ssnp_post_t post;
  ssnp_pkg::ssnp_post_t next_post;

  wire [AW:0] used = wr_ptr - rd_ptr;
  wire [AW:0] pend = wr_ptr - cmt_ptr;
  wire [AW:0] pend_inc = pend + ONE;
  assign ser_rx_ready = cfg.en && used != CAP;
  wire take = ser_rx_valid && ser_rx_ready;

  wire d1_on = cfg.d1 != 8'h00;
  wire d2_on = cfg.d2 != 8'h00;
  wire d1_seen = d1_on && ser_rx_data == cfg.d1;
  wire hit = d1_on && (d2_on ? (saw_d1 && ser_rx_data == cfg.d2) : d1_seen);
  wire proc_now = hit && post == ssnp_pkg::SSNP_PS_IDLE;
  wire strip_now = proc_now && cfg.proc == ssnp_pkg::SSNP_PROC_STRIP;
  wire delim_emit = proc_now && (cfg.proc == ssnp_pkg::SSNP_PROC_NONE || strip_now);
  wire post_done = post == ssnp_pkg::SSNP_PS_WAIT1;
  wire len_hit = cfg.len != 11'h000 && pend_inc >= (AW+1)'(cfg.len);
  wire full_hit = pend_inc == CAP;
  // any trigger on this byte folds into one frame
  wire byte_emit = take && (!d1_on || len_hit || full_hit || post_done || delim_emit);
  // one tick past the limit, so the gap is never shorter than the setting
  wire tmo_emit = !take && cfg.force_ms != 16'h0000 && pend != '0 &&
                  idle_ms > {1'b0, cfg.force_ms};
  wire emit = byte_emit || tmo_emit;
  wire [AW:0] strip_back = d2_on ? ONE : '0;
  wire [AW:0] next_wr = !take ? wr_ptr : strip_now ? wr_ptr - strip_back : wr_ptr + ONE;
  wire [AW:0] mark_at = next_wr - ONE;
  wire mark_we = emit && next_wr != cmt_ptr;

  always_ff @(posedge core_clk) begin
    if (take && !strip_now) begin
      buf_mem[wr_ptr[AW-1:0]] <= ser_rx_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      last_bits <= '0;
    end else begin
      if (take && !strip_now) begin
        last_bits[wr_ptr[AW-1:0]] <= 1'b0;
      end
      if (mark_we) begin
        last_bits[mark_at[AW-1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || !cfg.en) begin
      wr_ptr <= '0;
      cmt_ptr <= '0;
    end else begin
      wr_ptr <= next_wr;
      if (emit) begin
        cmt_ptr <= next_wr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || tmo_emit) begin
      saw_d1 <= 1'b0;
    end else if (take) begin
      saw_d1 <= d1_seen && !byte_emit;
    end
  end

  // gap timer restarts on each byte and on each emitted frame
  always_ff @(posedge core_clk) begin
    if (!rstn || take || emit) begin
      idle_ms <= 17'h0_0000;
    end else if (ms_tick && pend != '0 && idle_ms != 17'h1_FFFF) begin
      idle_ms <= idle_ms + 17'h0_0001;
    end
  end

  always_comb begin
    next_post = post;
    if (take) begin
      case (post)
        ssnp_pkg::SSNP_PS_IDLE: begin
          if (proc_now && cfg.proc == ssnp_pkg::SSNP_PROC_PLUS1) begin
            next_post = ssnp_pkg::SSNP_PS_WAIT1;
          end else if (proc_now && cfg.proc == ssnp_pkg::SSNP_PROC_PLUS2) begin
            next_post = ssnp_pkg::SSNP_PS_WAIT2;
          end
        end
        ssnp_pkg::SSNP_PS_WAIT2: next_post = ssnp_pkg::SSNP_PS_WAIT1;
        ssnp_pkg::SSNP_PS_WAIT1: next_post = ssnp_pkg::SSNP_PS_IDLE;
        default: next_post = ssnp_pkg::SSNP_PS_IDLE;
      endcase
    end
    if (emit || !cfg.en) begin
      next_post = ssnp_pkg::SSNP_PS_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      post <= ssnp_pkg::SSNP_PS_IDLE;
    end else begin
      post <= next_post;
    end
  end

  // host sessions
  wire multi = cfg.hosts > ssnp_pkg::HOSTS_MIN;
  wire [2:0] open_cnt = ssnp_count(host_open);
  wire [H-1:0] conn_grant = (cfg.en && open_cnt < cfg.hosts) ?
                            ssnp_first(host_conn_req & ~host_open) : '0;

  genvar gi;
  generate
    for (gi = 0; gi < H; gi++) begin : g_slot
      ssnp_host_slot u_slot (
        .core_clk(core_clk),
        .rstn(rstn),
        .open_req(conn_grant[gi]),
        .close_req(host_disc[gi] || !cfg.en),
        .activity(host_rx_valid[gi] || host_tx_valid[gi] || drv_cmd_valid[gi]),
        .min_tick(min_tick),
        .alive_min(cfg.alive),
        .open(host_open[gi])
      );
    end
  endgenerate

  // frame drain toward hosts
  wire skip_on = multi && cfg.skip;
  wire any_open = |host_open;
  wire all_ready = &(host_tx_ready | ~host_open);
  wire some_ready = |(host_tx_ready & host_open);
  wire frm_go = any_open && (skip_on ? some_ready : all_ready);
  assign frm_valid = cfg.en && rd_ptr != cmt_ptr;
  assign frm.data = buf_mem[rd_ptr[AW-1:0]];
  assign frm.last = last_bits[rd_ptr[AW-1:0]];
  // stalled hosts miss the byte when skipping is on
  assign host_tx_valid = (frm_valid && frm_go) ? (host_open & host_tx_ready) : '0;

  always_ff @(posedge core_clk) begin
    if (!rstn || !cfg.en) begin
      rd_ptr <= '0;
    end else if (frm_valid && frm_go) begin
      rd_ptr <= rd_ptr + ONE;
    end
  end

  // network to serial, one byte stage, per-host order kept
  wire tx_load = !ser_tx_valid || ser_tx_ready;
  wire [H-1:0] rx_sel = (cfg.en && tx_load) ? ssnp_first(host_rx_valid & host_open) : '0;
  assign host_rx_ready = rx_sel;
  logic [7:0] rx_pick;
  always_comb begin
    rx_pick = 8'h00;
    for (int i = 0; i < H; i++) begin
      rx_pick = rx_pick | (host_rx_data[i] & {8{rx_sel[i]}});
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || !cfg.en) begin
      ser_tx_valid <= 1'b0;
      ser_tx_data <= 8'h00;
    end else if (tx_load) begin
      ser_tx_valid <= |rx_sel;
      if (|rx_sel) begin
        ser_tx_data <= rx_pick;
      end
    end
  end

  // driver control commands
  wire cmd_ok = !multi || cfg.drv;
  wire [H-1:0] cmd_sel = (cfg.en && cmd_ok) ? ssnp_first(drv_cmd_valid & host_open) : '0;
  logic [15:0] cmd_pick;
  always_comb begin
    cmd_pick = 16'h0000;
    for (int i = 0; i < H; i++) begin
      cmd_pick = cmd_pick | (drv_cmd[i] & {16{cmd_sel[i]}});
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_word <= 16'h0000;
      ctrl_word_valid <= 1'b0;
      line_cfg <= 16'h0000;
    end else begin
      ctrl_word_valid <= |cmd_sel;
      if (|cmd_sel) begin
        ctrl_word <= cmd_pick;
      end
      if (multi) begin
        line_cfg <= cfg.line;
      end else if (|cmd_sel) begin
        line_cfg <= cmd_pick;
      end
    end
  end

  // register read, answered the cycle after the strobe
  wire [31:0] rd_mux =
    (reg_addr == ssnp_pkg::ADDR_CTRL) ? {{17{1'b0}}, cfg.alive, 1'b0, cfg.hosts,
                                         1'b0, cfg.drv, cfg.skip, cfg.en} :
    (reg_addr == ssnp_pkg::ADDR_PACK) ? {{14{1'b0}}, cfg.proc, 5'h00, cfg.len} :
    (reg_addr == ssnp_pkg::ADDR_DELIM) ? {16'h0000, cfg.d2, cfg.d1} :
    (reg_addr == ssnp_pkg::ADDR_FORCE) ? {16'h0000, cfg.force_ms} :
    (reg_addr == ssnp_pkg::ADDR_LINE) ? {16'h0000, cfg.line} :
    (reg_addr == ssnp_pkg::ADDR_STAT) ? {{15{1'b0}}, frm_valid, 1'b0, open_cnt,
                                         1'b0, 11'(used)} :
    (reg_addr == ssnp_pkg::ADDR_CMD) ? {16'h0000, ctrl_word} : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!rstn || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rd_mux;
    end
  end
endmodule : ssnp_packer
